// ---- design/mic_capture_phase_adapt.sv ----
`timescale 1ns/10ps
// Overview of operation
// RULE1: modulator clock driven out as mic clock
// RULE2: data latched on rising or falling edge
// RULE3: two stereo mic channels, four streams
// RULE4: mic one muxed with analog modulator input
// RULE5: both channels share one mic clock
// RULE6: each line carries mono or edge-interleaved stereo
// RULE7: source code 01 routes mic one to main
// RULE8: source code 01 routes mic two to secondary
// RULE9: edge bits 7,6,3,2 per stream
// RULE10: four-bit terminal select per stream
// RULE11: host keeps agc off with mic inputs
// RULE12: mic mode per left, right or both
// RULE13: analog section may power down in mic mode
// RULE14: host sets oversample ratio for microphone
// RULE15: right fine plus coarse delay, left sample delay
// RULE16: coarse scale 0.25, 0.5, 1 by filter
// RULE17: phase compensation on main path only
// RULE18: coefficients locked while running unless adaptive
// RULE19: adaptive enable gives two coefficient banks
// RULE20: swap at next sample start, self-clears, toggles
// RULE21: bank flag 0 for A, 1 for B
// RULE22: running writes go to idle bank
// RULE23: adaptive, swap and flag reset to zero
module mic_capture_phase_adapt
   import mic_capture_pkg::*;
#(
   parameter int terminals  = 16,   // selectable data terminals
   parameter int coef_depth = 64,   // coefficient words per bank
   parameter int mod_div    = 8     // sys_clk cycles per modulator half period
)(
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic      [7:0]            reg_rdata,
   input  wire logic [terminals-1:0]  mic_data_pin,
   output logic      [terminals-1:0]  mic_clock_out,
   output logic      [terminals-1:0]  mic_clock_oe,
   input  wire logic                  analog_mod_left,
   input  wire logic                  analog_mod_right,
   output logic                       main_left_bit,
   output logic                       main_right_bit,
   output logic                       main_bit_valid,
   output logic                       secondary_left_bit,
   output logic                       secondary_right_bit,
   output logic                       secondary_bit_valid,
   output logic                       sample_start,
   output logic                       analog_record_power,
   output logic      [23:0]           coef_active_data,
   input  wire logic [5:0]            coef_active_index
);
   import mic_capture_pkg::*;

   // register file
   logic [7:0] edge_sel;             // per-stream edge choice
   logic [7:0] one_term;             // mic one terminals
   logic [7:0] two_term;             // mic two terminals
   logic [7:0] phase_delay;          // delay register
   logic [7:0] main_src;             // main path source select
   logic [7:0] sec_src;              // secondary path source select
   logic [7:0] rec_cfg;              // run, analog power, filter, ratio
   logic [7:0] coef_ptr;             // coefficient pointer, bit 7 = bank B
   logic       adaptive_en;          // double buffer mode
   logic       swap_req;             // pending bank swap
   logic       bank_flag;            // 0 = bank A in use
   logic       coef_refused;         // sticky: access refused

   // modulator clock generation
   logic [7:0] div_cnt;              // half-period counter
   logic       mod_clk;              // modulator clock
   logic       rise_now;             // rising edge this cycle
   logic       fall_now;             // falling edge this cycle
   logic [7:0] mod_count;            // modulator periods in sample

   // pin sampling
   logic [terminals-1:0] pin_meta;   // first stage
   logic [terminals-1:0] pin_sync;   // second stage

   // captured streams: one left, one right, two left, two right
   logic [3:0] stream_bit;

   // phase delay lines
   logic [127:0] right_line;         // right delay taps in modulator periods
   logic         left_hold;          // left bit one sample back

   // coefficient banks
   logic [23:0] bank_a [coef_depth];
   logic [23:0] bank_b [coef_depth];
   logic [15:0] coef_stage;          // low bytes staged for a word

   // decoded fields
   wire running       = rec_cfg[run_bit];
   wire [1:0] ftype   = rec_cfg[filter_type_lsb +: 2];
   wire [3:0] osr_sel = rec_cfg[oversample_lsb +: 4];
   // ratio: 32 * 2^osr_sel capped at 128 for the counter
   wire [7:0] ratio   = (osr_sel >= 4'h2) ? 8'd128 : ((osr_sel == 4'h1) ? 8'd64 : 8'd32);

   // right delay: fine + coarse * ratio * kf  [RULE15] [RULE16]
   wire [7:0] kf_ratio = (ftype == filter_a) ? (ratio >> 2) :
                         (ftype == filter_b) ? (ratio >> 1) : ratio;
   wire [9:0] coarse   = 10'(phase_delay[6:5]) * 10'(kf_ratio);
   wire [9:0] tap_full = 10'(phase_delay[4:0]) + coarse;
   wire [6:0] tap      = (tap_full > 10'd127) ? 7'd127 : tap_full[6:0];

   // stream terminal picks  [RULE10]
   wire [3:0] t_one_l = one_term[7:4];
   wire [3:0] t_one_r = one_term[3:0];
   wire [3:0] t_two_l = two_term[7:4];
   wire [3:0] t_two_r = two_term[3:0];
   wire [3:0] sel_bits = {pin_sync[t_two_r], pin_sync[t_two_l],
                          pin_sync[t_one_r], pin_sync[t_one_l]};
   // edge choice per stream, 1 = rising  [RULE9]
   wire [3:0] edge_rise = {edge_sel[edge_two_right_bit], edge_sel[edge_two_left_bit],
                           edge_sel[edge_one_right_bit], edge_sel[edge_one_left_bit]};

   // main path sources  [RULE4] [RULE7] [RULE12]
   wire main_l_mic = (main_src[src_left_lsb +: 2] == src_mic);
   wire main_r_mic = (main_src[src_right_lsb +: 2] == src_mic);
   wire sec_l_mic  = (sec_src[src_left_lsb +: 2] == src_mic);
   wire sec_r_mic  = (sec_src[src_right_lsb +: 2] == src_mic);
   wire raw_left   = main_l_mic ? stream_bit[0] : analog_mod_left;
   wire raw_right  = main_r_mic ? stream_bit[1] : analog_mod_right;

   // coefficient access gate  [RULE18]
   wire coef_open  = !running || adaptive_en;
   wire [5:0] cidx = coef_ptr[5:0];
   // target bank: running writes go to idle bank  [RULE22]
   wire to_bank_b  = running ? !bank_flag : coef_ptr[7];
   wire coef_wr    = reg_write && (reg_addr == coef_data_addr) && coef_open;
   wire coef_bad   = (reg_write || reg_read) && (reg_addr == coef_data_addr) && !coef_open;
   wire word_done  = coef_wr && (coef_ptr[6] == 1'b1);
   wire ctrl_wr    = reg_write && (reg_addr == adaptive_coef_control_addr);
   wire sample_now = rise_now && (mod_count == ratio - 8'd1);

   // modulator clock divider  [RULE1] [RULE5]
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div_cnt <= 8'h00;
         mod_clk <= 1'b0;
      end else if (div_cnt == 8'(mod_div - 1)) begin
         div_cnt <= 8'h00;
         mod_clk <= !mod_clk;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   assign rise_now = (div_cnt == 8'(mod_div - 1)) && !mod_clk;
   assign fall_now = (div_cnt == 8'(mod_div - 1)) && mod_clk;

   // sample period counter in modulator periods
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mod_count <= 8'h00;
      end else if (rise_now) begin
         mod_count <= sample_now ? 8'h00 : mod_count + 8'h01;
      end
   end

   // same shared clock on every terminal, enabled when running  [RULE1] [RULE5]
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mic_clock_out <= '0;
         mic_clock_oe  <= '0;
      end else begin
         mic_clock_out <= {terminals{mod_clk}};
         mic_clock_oe  <= {terminals{running}};
      end
   end

   // two-stage pin synchroniser
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= mic_data_pin;
         pin_sync <= pin_meta;
      end
   end

   // latch each stream on its chosen edge  [RULE2] [RULE3] [RULE6]
   // pin delay is far below the half period, so the edge sample holds
   genvar s;
   generate
      for (s = 0; s < 4; s++) begin : g_stream
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               stream_bit[s] <= 1'b0;
            end else if (edge_rise[s] ? rise_now : fall_now) begin
               stream_bit[s] <= sel_bits[s];
            end
         end
      end
   endgenerate

   // delay lines on main path only  [RULE17]
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         right_line <= '0;
         left_hold  <= 1'b0;
      end else if (rise_now) begin
         right_line <= {right_line[126:0], raw_right};
         if (sample_now) begin
            left_hold <= raw_left;
         end
      end
   end

   // path outputs, one per modulator period
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         main_left_bit       <= 1'b0;
         main_right_bit      <= 1'b0;
         main_bit_valid      <= 1'b0;
         secondary_left_bit  <= 1'b0;
         secondary_right_bit <= 1'b0;
         secondary_bit_valid <= 1'b0;
         sample_start        <= 1'b0;
      end else begin
         main_bit_valid      <= rise_now && running;
         secondary_bit_valid <= rise_now && running && (sec_l_mic || sec_r_mic);
         sample_start        <= sample_now;
         if (rise_now) begin
            main_right_bit <= (tap == 7'd0) ? raw_right : right_line[tap - 7'd1];  // [RULE15]
            main_left_bit  <= phase_delay[7] ? left_hold : raw_left;           // [RULE15]
            secondary_left_bit  <= sec_l_mic ? stream_bit[2] : 1'b0;           // [RULE8]
            secondary_right_bit <= sec_r_mic ? stream_bit[3] : 1'b0;           // [RULE8]
         end
      end
   end

   // analog power off allowed when both main sides use mics  [RULE13]
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         analog_record_power <= 1'b0;
      end else begin
         analog_record_power <= rec_cfg[analog_power_bit] && !(main_l_mic && main_r_mic);
      end
   end

   // adaptive control: set wins over self-clear  [RULE19] [RULE20] [RULE23]
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         adaptive_en <= 1'b0;
         swap_req    <= 1'b0;
         bank_flag   <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            adaptive_en <= reg_wdata[adaptive_enable_bit];
         end
         if (ctrl_wr && reg_wdata[swap_request_bit] && adaptive_en && running) begin
            swap_req <= 1'b1;
         end else if (swap_req && sample_now) begin
            swap_req  <= 1'b0;                                              // [RULE20]
            bank_flag <= !bank_flag;                                        // [RULE21]
         end
      end
   end

   // coefficient storage, three bytes per word, low byte first
   always_ff @(posedge sys_clk) begin
      if (coef_wr && word_done) begin
         if (to_bank_b) begin
            bank_b[cidx] <= {reg_wdata, coef_stage};                        // [RULE22]
         end else begin
            bank_a[cidx] <= {reg_wdata, coef_stage};                        // [RULE22]
         end
      end
   end

   // active coefficient feed to filter engine  [RULE21]
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         coef_active_data <= 24'h000000;
      end else begin
         coef_active_data <= bank_flag ? bank_b[coef_active_index]
                                       : bank_a[coef_active_index];
      end
   end

   // plain register writes and coefficient staging
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         edge_sel     <= reg_reset;
         one_term     <= reg_reset;
         two_term     <= reg_reset;
         phase_delay  <= reg_reset;
         main_src     <= reg_reset;
         sec_src      <= reg_reset;
         rec_cfg      <= osr_reset;
         coef_ptr     <= reg_reset;
         coef_stage   <= 16'h0000;
         coef_refused <= 1'b0;
      end else begin
         if (reg_write) begin
            case (reg_addr)
               mic_edge_select_addr:                edge_sel    <= reg_wdata;
               mic_one_terminal_select_addr:        one_term    <= reg_wdata;
               mic_two_terminal_select_addr:        two_term    <= reg_wdata;
               channel_phase_delay_addr:            phase_delay <= reg_wdata;
               main_record_source_select_addr:      main_src    <= reg_wdata;
               secondary_record_source_select_addr: sec_src     <= reg_wdata;
               record_config_addr:                  rec_cfg     <= reg_wdata;
               coef_addr_addr:                      coef_ptr    <= reg_wdata & 8'h9f;
               default: ;
            endcase
         end
         // byte staging: bits 6:5 of pointer count bytes 0..2  [RULE18]
         if (coef_wr) begin
            case (coef_ptr[6:5])
               2'b00:   coef_stage[7:0]  <= reg_wdata;
               2'b01:   coef_stage[15:8] <= reg_wdata;
               default: ;
            endcase
            coef_ptr[6:5] <= (coef_ptr[6:5] == 2'b10) ? 2'b00 : coef_ptr[6:5] + 2'b01;
         end
         // refusal flag: set wins over read clear
         if (coef_bad) begin
            coef_refused <= 1'b1;                                           // [RULE18]
         end else if (reg_read && (reg_addr == status_addr)) begin
            coef_refused <= 1'b0;
         end
      end
   end
   // read mux
   wire [23:0] rd_word = coef_ptr[7] ? bank_b[cidx] : bank_a[cidx];
   wire [7:0]  rd_coef = !coef_open ? 8'h00 :
                         (coef_ptr[6:5] == 2'b00) ? rd_word[7:0] :
                         (coef_ptr[6:5] == 2'b01) ? rd_word[15:8] : rd_word[23:16];
   wire [7:0]  rd_mux  =
      (reg_addr == adaptive_coef_control_addr) ?
         {5'h00, adaptive_en, bank_flag, swap_req} :
      (reg_addr == mic_edge_select_addr)                ? edge_sel    :
      (reg_addr == mic_one_terminal_select_addr)        ? one_term    :
      (reg_addr == mic_two_terminal_select_addr)        ? two_term    :
      (reg_addr == channel_phase_delay_addr)            ? phase_delay :
      (reg_addr == main_record_source_select_addr)      ? main_src    :
      (reg_addr == secondary_record_source_select_addr) ? sec_src     :
      (reg_addr == record_config_addr)                  ? rec_cfg     :
      (reg_addr == coef_addr_addr)                      ? coef_ptr    :
      (reg_addr == coef_data_addr)                      ? rd_coef     :
      (reg_addr == status_addr) ? {6'h00, coef_refused, running}   : unmapped_read;

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_read ? rd_mux : 8'h00;
      end
   end
endmodule

// ---- shared/mic_capture_pkg.sv ----
package mic_capture_pkg;
   // register offsets
   localparam logic [7:0] adaptive_coef_control_addr   = 8'h01;
   localparam logic [7:0] channel_phase_delay_addr     = 8'h55;
   localparam logic [7:0] mic_edge_select_addr         = 8'h64;
   localparam logic [7:0] mic_one_terminal_select_addr = 8'h65;
   localparam logic [7:0] mic_two_terminal_select_addr = 8'h66;
   localparam logic [7:0] main_record_source_select_addr      = 8'h51;
   localparam logic [7:0] secondary_record_source_select_addr = 8'h70;
   localparam logic [7:0] record_config_addr           = 8'h3d;
   localparam logic [7:0] coef_addr_addr               = 8'h80;
   localparam logic [7:0] coef_data_addr               = 8'h81;
   localparam logic [7:0] status_addr                  = 8'h82;
   // field positions
   localparam int adaptive_enable_bit = 2;
   localparam int bank_flag_bit       = 1;
   localparam int swap_request_bit    = 0;
   localparam int edge_one_left_bit   = 7;
   localparam int edge_one_right_bit  = 6;
   localparam int edge_two_left_bit   = 3;
   localparam int edge_two_right_bit  = 2;
   localparam int src_left_lsb        = 4;
   localparam int src_right_lsb       = 2;
   // record_config fields
   localparam int run_bit             = 0;
   localparam int analog_power_bit    = 1;
   localparam int filter_type_lsb     = 2;
   localparam int oversample_lsb      = 4;
   // source select code for microphone
   localparam logic [1:0] src_mic     = 2'b01;
   // filter type codes
   localparam logic [1:0] filter_a    = 2'b00;
   localparam logic [1:0] filter_b    = 2'b01;
   // reset values
   localparam logic [7:0] reg_reset   = 8'h00;
   localparam logic [7:0] osr_reset   = 8'h04;
   // bus read data for unmapped address
   localparam logic [7:0] unmapped_read = 8'h00;
endpackage

// ---- tb/mic_capture_asserts.sv ----
`timescale 1ns/10ps
// port-level checks of the capture front end
module mic_capture_asserts
   import mic_capture_pkg::*;
#(
   parameter int terminals = 16,  // data terminals
   parameter int mod_div   = 8    // sys_clk cycles per modulator half period
)(
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   input  wire logic [7:0]           reg_rdata,
   input  wire logic [terminals-1:0] mic_clock_out,
   input  wire logic [terminals-1:0] mic_clock_oe,
   input  wire logic                 main_bit_valid,
   input  wire logic                 secondary_bit_valid,
   input  wire logic                 sample_start
);
   localparam int half = mod_div;  // cycles between clock edges
   // plain read/write registers
   wire rw_hit = reg_addr inside {8'h55, 8'h64, 8'h65, 8'h66, 8'h51, 8'h70};
   // every decoded address
   wire mapped = rw_hit || (reg_addr inside {8'h01, 8'h3d, 8'h80, 8'h81, 8'h82});
   wire cfg_hit = reg_addr == record_config_addr;  // record config access
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // write, idle cycle, read of the same place
   sequence rw_write;
      reg_write && rw_hit;
   endsequence
   sequence same_read;
      reg_read && reg_addr == $past(reg_addr, 2);
   endsequence
   a_reg_readback: assert property (rw_write ##1 !reg_write ##1 same_read
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("register readback wrong");
   a_read_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata == unmapped_read)
      else $error("unmapped read not zero");
   a_oe_run: assert property (reg_write && cfg_hit && reg_wdata[run_bit]
      |-> ##2 (&mic_clock_oe)) else $error("clock enables not on after run");
   a_clock_copy: assert property (mic_clock_out == {terminals{mic_clock_out[0]}})
      else $error("terminal clocks differ");
   a_clock_half: assert property ($rose(mic_clock_out[0]) |->
      ##half $fell(mic_clock_out[0])) else $error("mic clock half period wrong");
   a_valid_gap: assert property (main_bit_valid |=> !main_bit_valid [*3])
      else $error("main valid too close");
   a_second_gap: assert property (secondary_bit_valid |=> !secondary_bit_valid [*3])
      else $error("secondary valid too close");
   a_sample_gap: assert property (sample_start |=> !sample_start [*8])
      else $error("sample starts too close");
   a_reset_quiet: assert property ($fell(reset) |-> reg_rdata == 8'h00 && !main_bit_valid
      && !sample_start && mic_clock_oe == '0) else $error("outputs active after reset");
endmodule

bind mic_capture_phase_adapt mic_capture_asserts #(.terminals(terminals), .mod_div(mod_div))
   mic_capture_asserts_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .mic_clock_out(mic_clock_out), .mic_clock_oe(mic_clock_oe),
   .main_bit_valid(main_bit_valid), .secondary_bit_valid(secondary_bit_valid),
   .sample_start(sample_start));

// ---- tb/mic_stream_model.sv ----
`timescale 1ns/10ps
// two microphones sharing one data line, one per clock edge
module mic_stream_model #(
   parameter logic left_bit  = 1'b1,  // constant left stream
   parameter logic right_bit = 1'b0   // constant right stream
)(
   input  wire logic sys_clk,
   input  wire logic mic_bit_clock,
   input  wire logic selected,
   output logic      data_line
);
   logic stream = left_bit;  // value the mics put on the line
   logic filler = 1'b0;      // toggling pattern while released
   // right mic drives after the rising edge, left mic after the falling edge
   always @(posedge mic_bit_clock) stream <= right_bit;
   always @(negedge mic_bit_clock) stream <= left_bit;
   // clock enable off: nobody drives, no stable level
   always @(posedge sys_clk) filler <= ~filler;
   assign data_line = selected ? stream : filler;
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import mic_capture_pkg::*;
   logic        sys_clk;            // system clock
   logic        reset;              // sync reset
   logic [7:0]  reg_addr;           // bus address
   logic [7:0]  reg_wdata;          // bus write data
   logic        reg_write;          // write strobe
   logic        reg_read;           // read strobe
   logic [7:0]  reg_rdata;          // read data
   logic [15:0] mic_data_pin;       // data terminals
   logic [15:0] mic_clock_out;      // mic clock copies
   logic [15:0] mic_clock_oe;       // clock enables
   logic        analog_mod_left;    // analog left stream
   logic        analog_mod_right;   // analog right stream
   logic        main_left_bit;      // main path left
   logic        main_right_bit;     // main path right
   logic        main_bit_valid;     // main path strobe
   logic        sec_left;           // secondary left
   logic        sec_right;          // secondary right
   logic        sec_valid;          // secondary strobe
   logic        sample_start;       // sample period start
   logic        analog_power;       // analog section power
   logic [23:0] coef_active_data;   // active coefficient
   logic [5:0]  coef_active_index;  // coefficient index
   logic        mic_a;              // line of first mic pair
   logic        mic_b;              // line of second mic pair
   int          error_cnt = 0;      // mismatches
   int          check_count = 0;    // comparisons
   int          cycles = 0;         // timeout counter
   logic [23:0] rows [8];           // address, write data, read back
   logic [7:0]  regs [8];           // addresses for reset values
   logic [15:0] setup [6];          // address, data for capture setup
   wire  [2:0]  pulses = {sample_start, sec_valid, main_bit_valid};
   assign mic_data_pin = {{14{~mic_a}}, mic_b, mic_a};
   mic_capture_phase_adapt #(.mod_div(4)) mic_capture_phase_adapt_i (.sys_clk(sys_clk),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .mic_data_pin(mic_data_pin),
      .mic_clock_out(mic_clock_out), .mic_clock_oe(mic_clock_oe),
      .analog_mod_left(analog_mod_left), .analog_mod_right(analog_mod_right),
      .main_left_bit(main_left_bit), .main_right_bit(main_right_bit),
      .main_bit_valid(main_bit_valid), .secondary_left_bit(sec_left),
      .secondary_right_bit(sec_right), .secondary_bit_valid(sec_valid),
      .sample_start(sample_start), .analog_record_power(analog_power),
      .coef_active_data(coef_active_data), .coef_active_index(coef_active_index));
   mic_stream_model #(.left_bit(1'b1), .right_bit(1'b0)) mic_stream_model_i (
      .sys_clk(sys_clk), .mic_bit_clock(mic_clock_out[0]), .selected(mic_clock_oe[0]),
      .data_line(mic_a));
   mic_stream_model #(.left_bit(1'b0), .right_bit(1'b1)) mic_stream_model_b_i (
      .sys_clk(sys_clk), .mic_bit_clock(mic_clock_out[0]), .selected(mic_clock_oe[0]),
      .data_line(mic_b));
   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // counts and verdict
   task final_report;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // compare and report
   task chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle write
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   // one-cycle read, data checked in the following cycle
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask
   // pointer then three coefficient bytes, low first
   task coef(input logic [7:0] p, input logic [23:0] w);
      wr(8'h80, p);
      for (int i = 0; i < 3; i++) wr(8'h81, w[8*i +: 8]);
   endtask
   // wait for k strobes of one kind, bounded
   task pulse(input int sel, input int k);
      int n;
      n = 0;
      repeat (k) begin
         @(negedge sys_clk);
         while (pulses[sel] !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
         end
      end
      if (n >= 1000) chk(24'h1, 24'h0);
   endtask
   // path bits after the pipeline has filled
   task expect_bits(input int sel, input logic l, input logic r);
      pulse(sel, 4);
      chk(sel ? {sec_left, sec_right} : {main_left_bit, main_right_bit}, {l, r});
   endtask
   // hang guard
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         final_report;
      end
   end
   initial begin
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      analog_mod_left = 1'b1;
      analog_mod_right = 1'b0;
      coef_active_index = 6'h00;
      rows = '{24'h552121, 24'h64cccc, 24'h65a5a5, 24'h663c3c,
               24'h511414, 24'h701414, 24'h010704, 24'h20ff00};
      regs = '{8'h01, 8'h55, 8'h64, 8'h65, 8'h66, 8'h51, 8'h70, 8'h3d};
      setup = '{16'h6488, 16'h6500, 16'h6611, 16'h5114, 16'h7014, 16'h5500};
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      // register rows, with adaptive control and an unmapped address: write then read back
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      // second reset in mid-run
      @(posedge sys_clk) reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      foreach (regs[i]) rd(regs[i], (regs[i] == 8'h3d) ? osr_reset : reg_reset);
      // capture setup, stopped coefficient loads, then run
      foreach (setup[i]) wr(setup[i][15:8], setup[i][7:0]);
      coef(8'h00, 24'h332211);
      coef(8'h80, 24'h665544);
      wr(8'h3d, 8'h03);
      expect_bits(0, 1'b1, 1'b0);
      expect_bits(1, 1'b0, 1'b1);
      chk(analog_power, 1'b0);
      chk(mic_clock_oe, 16'hffff);
      chk(coef_active_data, 24'h332211);
      // swap sampling edges on every stream
      wr(8'h64, 8'h44);
      expect_bits(0, 1'b0, 1'b1);
      expect_bits(1, 1'b1, 1'b0);
      // analog source, then left side only on microphone
      wr(8'h51, 8'h00);
      expect_bits(0, 1'b1, 1'b0);
      chk(analog_power, 1'b1);
      wr(8'h51, 8'h10);
      expect_bits(0, 1'b0, 1'b0);
      // right delay: 1 fine plus 1 coarse of 32 * 0.25, so 9 periods
      wr(8'h55, 8'h21);
      analog_mod_right <= 1'b1;
      pulse(0, 9);
      chk(main_right_bit, 1'b0);
      pulse(0, 2);
      chk(main_right_bit, 1'b1);
      // coefficient access refused while running
      wr(8'h81, 8'hee);
      rd(8'h81, 8'h00);
      rd(8'h82, 8'h03);
      rd(8'h82, 8'h01);
      // adaptive mode: write lands in idle bank, swap at sample start
      wr(8'h01, 8'h04);
      coef(8'h00, 24'h998877);
      pulse(2, 1);
      chk(coef_active_data, 24'h332211);
      wr(8'h01, 8'h05);
      pulse(2, 2);
      rd(8'h01, 8'h06);
      chk(coef_active_data, 24'h998877);
      final_report;
   end
endmodule
